// >>> verilog/sbt_timer.sv
// Chosen here: register access over Avalon-MM and the placing of the registers.
`default_nettype none
`include "sbt_cfg.svh"
module sbt_timer
  import sbt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic external_count_input,
  input wire logic cpu_idle,
  output logic irq
);
  // ==========================================================
  // State
  sbt_word_t count_value;
  sbt_word_t period_value;
  sbt_word_t timer_control_reg;
  logic [1:0] status;
  logic [1:0] mask;
  logic [7:0] pre_cnt;
  logic ext_level;
  logic ext_prev;

  sbt_word_t next_count_value;
  sbt_word_t next_period_value;
  sbt_word_t next_timer_control_reg;
  logic [1:0] next_status;
  logic [1:0] next_mask;
  logic [7:0] next_pre_cnt;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic next_irq;

  // ==========================================================
  // Control fields
  logic timer_run_enable;
  logic idle_stop_bit;
  logic gate_accumulate_enable;
  logic external_sync_select;
  logic clock_source_select;
  sbt_div_e input_divider_select;
  sbt_mode_e mode;

  assign timer_run_enable = timer_control_reg[`SBT_BIT_RUN];
  assign idle_stop_bit = timer_control_reg[`SBT_BIT_IDLE_STOP];
  assign gate_accumulate_enable = timer_control_reg[`SBT_BIT_GATE];
  assign external_sync_select = timer_control_reg[`SBT_BIT_SYNC];
  assign clock_source_select = timer_control_reg[`SBT_BIT_SRC];
  assign input_divider_select = sbt_div_e'(timer_control_reg[`SBT_DIV_HI:`SBT_DIV_LO]); // RULE8

  always_comb begin
    if (clock_source_select) begin
      mode = external_sync_select ? SBT_MODE_SYNC_CNT : SBT_MODE_ASYNC_CNT; // RULE12
    end else begin
      mode = gate_accumulate_enable ? SBT_MODE_GATED : SBT_MODE_TIMER;
    end
  end

  // ==========================================================
  // External input, three-stage sampled
  sbt_pin_sync #(
    .RESET_LEVEL(1'b0)
  ) u_ext_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(external_count_input),
    .level(ext_level)
  );

  logic ext_rise;
  logic ext_fall;
  assign ext_rise = ext_level & ~ext_prev;
  assign ext_fall = ~ext_level & ext_prev;

  // ==========================================================
  // Count source and idle halt
  logic src_tick;
  logic halted;
  logic gate_end;
  logic [7:0] pre_last;

  always_comb begin
    unique case (mode)
      SBT_MODE_TIMER: src_tick = 1'b1; // RULE1
      SBT_MODE_GATED: src_tick = ext_level; // RULE9
      SBT_MODE_SYNC_CNT: src_tick = ext_rise; // RULE2
      SBT_MODE_ASYNC_CNT: src_tick = ext_rise; // RULE3
    endcase
  end

  // Idle stop applies in every mode; resumes with count untouched
  assign halted = cpu_idle & idle_stop_bit; // RULE4 RULE5 RULE6
  assign gate_end = timer_run_enable & (mode == SBT_MODE_GATED) & ext_fall;

  always_comb begin
    unique case (input_divider_select)
      SBT_DIV_1: pre_last = `SBT_PRE_LAST_1;
      SBT_DIV_8: pre_last = `SBT_PRE_LAST_8;
      SBT_DIV_64: pre_last = `SBT_PRE_LAST_64;
      SBT_DIV_256: pre_last = `SBT_PRE_LAST_256;
    endcase
  end

  // ==========================================================
  // Bus decode
  logic [9:0] idx;
  logic access;
  logic wr_now;
  sbt_word_t wmerge_mask;
  assign idx = avs_address[11:2];
  // Write lands on the edge where the master sees waitrequest low
  assign access = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_now = avs_write & ~avs_waitrequest;
  assign wmerge_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  function automatic sbt_word_t merge(input sbt_word_t old_v, input sbt_word_t new_v,
                                      input sbt_word_t m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // ==========================================================
  // Prescaler group
  logic step;
  logic count_wr;
  assign count_wr = wr_now && (idx == `SBT_IDX_COUNT);

  // Held at zero while stopped, so a restart always runs a full divide period
  // Compare with >= so a smaller divider chosen mid-period ends it at once
  always_comb begin
    next_pre_cnt = pre_cnt;
    step = 1'b0;
    if (!timer_run_enable) begin
      next_pre_cnt = `SBT_RST_PRE; // RULE11
    end else if (src_tick && !halted) begin
      if (pre_cnt >= pre_last) begin
        next_pre_cnt = `SBT_RST_PRE; // RULE10
        step = 1'b1;
      end else begin
        next_pre_cnt = pre_cnt + 8'h01; // RULE10
      end
    end
    if (count_wr) begin
      next_pre_cnt = `SBT_RST_PRE; // RULE11
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre_cnt <= `SBT_RST_PRE; // RULE11
    end else begin
      pre_cnt <= next_pre_cnt;
    end
  end

  // ==========================================================
  // Count group
  logic match;

  // Wrap comes on the step after equality, so the period value is itself counted
  always_comb begin
    next_count_value = count_value;
    match = 1'b0;
    if (step) begin
      if (count_value == period_value) begin
        next_count_value = `SBT_RST_COUNT; // RULE1 RULE2 RULE3
        match = 1'b1; // RULE13
      end else begin
        next_count_value = count_value + 16'h0001;
      end
    end
    // Software wins over a step in the same cycle
    if (count_wr) begin
      next_count_value = merge(count_value, avs_writedata[15:0], wmerge_mask);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_value <= `SBT_RST_COUNT;
    end else begin
      count_value <= next_count_value;
    end
  end

  // ==========================================================
  // Configuration group
  always_comb begin
    next_period_value = period_value;
    next_timer_control_reg = timer_control_reg;
    next_mask = mask;
    if (wr_now && idx == `SBT_IDX_PERIOD) begin
      next_period_value = merge(period_value, avs_writedata[15:0], wmerge_mask);
    end
    // Reserved bits are masked on write so they always read zero
    if (wr_now && idx == `SBT_IDX_CONTROL) begin
      // Count deliberately untouched here
      next_timer_control_reg = merge(timer_control_reg, avs_writedata[15:0],
                                     wmerge_mask & `SBT_CONTROL_WMASK); // RULE8 RULE11
    end
    if (wr_now && idx == `SBT_IDX_MASK && avs_byteenable[0]) begin
      next_mask = avs_writedata[1:0] & `SBT_ST_WMASK;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      period_value <= `SBT_RST_PERIOD;
      timer_control_reg <= `SBT_RST_CONTROL;
      mask <= `SBT_RST_MASK;
    end else begin
      period_value <= next_period_value;
      timer_control_reg <= next_timer_control_reg;
      mask <= next_mask;
    end
  end

  // ==========================================================
  // Status and interrupt group
  always_comb begin
    next_status = status;
    if (wr_now && idx == `SBT_IDX_STATUS && avs_byteenable[0]) begin
      next_status = status & ~avs_writedata[1:0];
    end
    // Hardware set wins over a same-cycle clear, so no event is lost
    if (match) begin
      next_status[`SBT_ST_MATCH] = 1'b1; // RULE7 RULE13
    end
    if (gate_end) begin
      next_status[`SBT_ST_GATE_FALL] = 1'b1; // RULE7 RULE13
    end
    // Built from next status so irq rises with the flag, not a cycle later
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status <= `SBT_RST_STATUS;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= next_irq;
    end
  end

  // ==========================================================
  // Edge detector history
  // Reset to the pin's idle low, so no false edge follows reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_level;
    end
  end

  // ==========================================================
  // Register read mux
  logic [31:0] reg_rdata;

  // Unmapped indices read zero
  always_comb begin
    reg_rdata = 32'h0000_0000;
    unique case (idx)
      `SBT_IDX_COUNT: reg_rdata[15:0] = count_value;
      `SBT_IDX_PERIOD: reg_rdata[15:0] = period_value;
      `SBT_IDX_CONTROL: reg_rdata[15:0] = timer_control_reg;
      `SBT_IDX_STATUS: reg_rdata[1:0] = status;
      `SBT_IDX_MASK: reg_rdata[1:0] = mask;
      default: reg_rdata = 32'h0000_0000;
    endcase
  end

  // Bus answer: one wait cycle, read data registered with it
  always_comb begin
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata;
    // A request still high after its answer starts the next access
    if ((avs_read || avs_write) && avs_waitrequest) begin
      next_waitrequest = 1'b0;
      next_readdata = reg_rdata;
    end else if (access) begin
      next_waitrequest = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end else begin
      avs_readdata <= next_readdata;
      avs_waitrequest <= next_waitrequest;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/sbt_cfg.svh
// How it works
// RULE1: In timer mode the count steps once per instruction cycle and wraps to zero after it equals the period value.
// RULE2: In synchronous counter mode the external input is synchronised first, then each rising edge steps the count with the same wrap.
// RULE3: In asynchronous counter mode each rising edge of the external input steps the count, wrapping after the period value.
// RULE4: In timer and synchronous counter modes counting halts during CPU idle when the idle stop bit is one, and goes on when it is zero.
// RULE5: After an idle halt the count resumes from its held value as soon as idle ends.
// RULE6: In asynchronous counter mode counting also halts during CPU idle when the idle stop bit is one.
// RULE7: An interrupt request is raised on a period match and on the falling edge of the gate input.
// RULE8: Mode, gating and prescaling are selected from one 16-bit control register written by software.
// RULE9: In gated mode, enabled with the internal clock, instruction cycles are counted only while the gate input is high.
// RULE10: The input clock is divided by 1, 8, 64 or 256 by a two-bit prescale field before it reaches the count.
// RULE11: The prescaler clears on a count write, on clearing the run bit and on reset; a control write leaves the count alone.
// RULE12: With the external source selected, the sync select bit at zero means asynchronous and at one synchronous counting.
// RULE13: The interrupt flag stays set until software clears it, and the match is checked on every count update.
`ifndef SBT_CFG_SVH
`define SBT_CFG_SVH

// ==========================================================
// Register indices, byte address is four times the index
`define SBT_IDX_COUNT 10'h100
`define SBT_IDX_PERIOD 10'h102
`define SBT_IDX_CONTROL 10'h104
`define SBT_IDX_STATUS 10'h106
`define SBT_IDX_MASK 10'h108

// ==========================================================
// Control fields
`define SBT_BIT_RUN 15
`define SBT_BIT_IDLE_STOP 13
`define SBT_BIT_GATE 6
`define SBT_DIV_HI 5
`define SBT_DIV_LO 4
`define SBT_BIT_SYNC 2
`define SBT_BIT_SRC 1
`define SBT_CONTROL_WMASK 16'hA076

// ==========================================================
// Status and mask fields
`define SBT_ST_MATCH 0
`define SBT_ST_GATE_FALL 1
`define SBT_ST_WMASK 2'h3

// ==========================================================
// Reset values
`define SBT_RST_COUNT 16'h0000
`define SBT_RST_PERIOD 16'hFFFF
`define SBT_RST_CONTROL 16'h0000
`define SBT_RST_STATUS 2'h0
`define SBT_RST_MASK 2'h0
`define SBT_RST_PRE 8'h00

// ==========================================================
// Prescaler terminal counts for 1, 8, 64 and 256
`define SBT_PRE_LAST_1 8'h00
`define SBT_PRE_LAST_8 8'h07
`define SBT_PRE_LAST_64 8'h3F
`define SBT_PRE_LAST_256 8'hFF

`endif

// >>> verilog/sbt_pkg.sv
`default_nettype none
package sbt_pkg;
  typedef logic [15:0] sbt_word_t;
  typedef enum logic [1:0] {
    SBT_DIV_1,
    SBT_DIV_8,
    SBT_DIV_64,
    SBT_DIV_256
  } sbt_div_e;
  typedef enum logic [1:0] {
    SBT_MODE_TIMER,
    SBT_MODE_GATED,
    SBT_MODE_SYNC_CNT,
    SBT_MODE_ASYNC_CNT
  } sbt_mode_e;
endpackage
`default_nettype wire

// >>> verilog/sbt_pin_sync.sv
`default_nettype none
module sbt_pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  // Level only moves once the second and third stages agree
  always_comb begin
    next_level = level;
    if (s2 == s3) begin
      next_level = s3;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1 <= RESET_LEVEL;
      s2 <= RESET_LEVEL;
      s3 <= RESET_LEVEL;
      level <= RESET_LEVEL;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/sbt_timer_chk.sv
`default_nettype none
module sbt_timer_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Bus and interrupt checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic req = avs_read || avs_write;
  bus_answer_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  wait_idle_a: assert property (!req && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  data_hold_a: assert property (!req && !$past(req) |-> $stable(avs_readdata))
    else $error("read data moved while idle");
  ctrl_reserved_a: assert property (!avs_waitrequest && avs_read &&
    avs_address[11:2] == 10'h104 |-> (avs_readdata[15:0] & 16'h5F89) == 16'h0000)
    else $error("reserved control bit read one");
  irq_clear_a: assert property ($fell(irq) |->
    $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("irq dropped without a write");
  reset_exit_a: assert property ($past(rst) |-> !irq && avs_waitrequest)
    else $error("bad state after reset");
endmodule
`default_nettype wire

// >>> testbench/sbt_ext_src.sv
`default_nettype none
module sbt_ext_src (
  input wire logic ref_clk,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin = 1'b0;
  // Edges spaced past the 3-flop sync delay
  task automatic pulses(input int n, input int w);
    repeat (n) begin
      @(posedge ref_clk) pin <= 1'b1;
      repeat (w) @(posedge ref_clk);
      pin <= 1'b0;
      repeat (w) @(posedge ref_clk);
    end
  endtask
  task automatic hold(input logic v);
    @(posedge ref_clk) pin <= v;
  endtask
endmodule
`default_nettype wire

// >>> testbench/sbt_timer_tb_top.sv
`default_nettype none
module sbt_timer_tb_top import sbt_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] a_cnt = 12'h400, a_per = 12'h408, a_ctl = 12'h410;
  localparam logic [11:0] a_st = 12'h418, a_msk = 12'h420;
  logic ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, cpu_idle = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, irq, ext_pin;
  int bad_count = 0, checks_done = 0;
  int dv[4] = '{1, 8, 64, 256};
  sbt_word_t rd, v;
  always #50 ref_clk = ~ref_clk;
  sbt_timer u_sbt_timer (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h3), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .external_count_input(ext_pin), .cpu_idle(cpu_idle), .irq(irq));
  sbt_ext_src u_sbt_ext_src (.ref_clk(ref_clk), .pin(ext_pin));
  // ==========================================
  // Bus and compare helpers
  task automatic chk(input sbt_word_t g, input sbt_word_t e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_in(input sbt_word_t g, input sbt_word_t lo, input sbt_word_t hi);
    checks_done++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      bad_count++;
      $display("mismatch %0t got %h range %h %h", $time, g, lo, hi);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input sbt_word_t d);
    int n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk_in(n, 2, 2);
  endtask
  task automatic wr(input logic [11:0] a, input sbt_word_t d);
    bus(1'b1, a, d);
  endtask
  task automatic rdq(input logic [11:0] a);
    bus(1'b0, a, 16'h0000);
  endtask
  task automatic rdc(input logic [11:0] a, input sbt_word_t e);
    rdq(a);
    chk(rd, e);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    rdc(a_cnt, 16'h0000);
    rdc(a_per, 16'hFFFF);
    rdc(a_st, 16'h0000);
    rdc(12'h7FC, 16'h0000);
    wr(a_ctl, 16'hFFFF);
    rdc(a_ctl, 16'hA076);
    wr(a_ctl, 16'h0000);
  endtask
  task automatic t_wrap();
    wr(a_per, 16'h0002);
    wr(a_cnt, 16'h0000);
    wr(a_ctl, 16'h8000);
    repeat (5) begin
      rdq(a_cnt);
      chk_in(rd, 16'h0000, 16'h0002);
    end
    wr(a_ctl, 16'h0000);
    rdc(a_st, 16'h0001);
    wr(a_msk, 16'h0001);
    repeat (2) @(posedge ref_clk);
    chk({15'h0000, irq}, 16'h0001);
    wr(a_st, 16'h0001);
    repeat (2) @(posedge ref_clk);
    chk({15'h0000, irq}, 16'h0000);
    wr(a_per, 16'hFFFF);
  endtask
  task automatic t_div();
    for (int k = 0; k < 4; k++) begin
      wr(a_cnt, 16'h0000);
      wr(a_ctl, 16'h8000 | (k << 4));
      repeat (100 * dv[k]) @(posedge ref_clk);
      wr(a_ctl, 16'h0000);
      rdq(a_cnt);
      chk_in(rd, 16'h0063, 16'h0068);
      v = rd;
      wr(a_ctl, 16'h0030);
      rdc(a_cnt, v);
    end
  endtask
  task automatic t_idle();
    wr(a_ctl, 16'hA000);
    @(posedge ref_clk) cpu_idle <= 1'b1;
    rdq(a_cnt);
    v = rd;
    repeat (20) @(posedge ref_clk);
    rdc(a_cnt, v);
    @(posedge ref_clk) cpu_idle <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rdq(a_cnt);
    chk_in(rd, v + 16'h0014, v + 16'h001E);
    wr(a_ctl, 16'h8000);
    @(posedge ref_clk) cpu_idle <= 1'b1;
    rdq(a_cnt);
    v = rd;
    repeat (20) @(posedge ref_clk);
    rdq(a_cnt);
    chk_in(rd, v + 16'h0014, v + 16'h001A);
    @(posedge ref_clk) cpu_idle <= 1'b0;
  endtask
  task automatic t_ext(input sbt_word_t c, input logic idl);
    wr(a_ctl, 16'h0000);
    wr(a_cnt, 16'h0000);
    wr(a_ctl, c);
    @(posedge ref_clk) cpu_idle <= idl;
    u_sbt_ext_src.pulses(10, 6);
    repeat (8) @(posedge ref_clk);
    rdc(a_cnt, idl ? 16'h0000 : 16'h000A);
    @(posedge ref_clk) cpu_idle <= 1'b0;
  endtask
  task automatic t_gate();
    wr(a_ctl, 16'h0000);
    wr(a_cnt, 16'h0000);
    wr(a_msk, 16'h0002);
    wr(a_ctl, 16'h8040);
    u_sbt_ext_src.hold(1'b1);
    repeat (50) @(posedge ref_clk);
    u_sbt_ext_src.hold(1'b0);
    repeat (8) @(posedge ref_clk);
    rdq(a_cnt);
    chk_in(rd, 16'h0031, 16'h0035);
    rdc(a_st, 16'h0002);
    chk({15'h0000, irq}, 16'h0001);
    wr(a_st, 16'h0002);
    repeat (2) @(posedge ref_clk);
    chk({15'h0000, irq}, 16'h0000);
  endtask
  task automatic results();
    $display("bad %0d checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_wrap();
    t_div();
    t_idle();
    t_ext(16'h8006, 1'b0);
    t_ext(16'h8002, 1'b0);
    t_ext(16'hA002, 1'b1);
    t_gate();
    results();
  end
  // Span of all tests is near 34000 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    results();
  end
endmodule
bind sbt_timer sbt_timer_chk u_sbt_timer_chk (.ref_clk(ref_clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
`default_nettype wire
